// File: hw/otpc_pkg.sv
// package for the one-time-programmable memory host controller
// assumes one 200 MHz clock; supply switches are outside, driven by levels from here
package otpc_pkg;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int PAGE_WORDS = 8;
    localparam int PULSE_US = 50;
    localparam int CLK_MHZ = 200;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int MAX_PULSES = 25;
    localparam int SETTLE_CYC = 4;
    localparam int ACCESS_CYC = 32;
    localparam int PAGE_CYC = 16;
    localparam int SUPPLY_CYC = 200;

    typedef enum logic [2:0] {
        OTPC_CMD_READ,
        OTPC_CMD_PROG,
        OTPC_CMD_IDENT,
        OTPC_CMD_VERIFY_ALL
    } otpc_cmd_t;

    typedef struct packed {
        otpc_cmd_t             cmd;
        logic [ADDR_W-1:0]     addr;
        logic [ADDR_W-1:0]     last;
        logic                  byte_mode;
        logic                  byte_hi;
    } otpc_req_t;

    typedef struct packed {
        logic                  ce_n;
        logic                  oe_n;
        logic                  prog_supply;
        logic                  core_high;
        logic                  ident_hv;
        logic                  byte_sel_n;
        logic [ADDR_W-1:0]     addr;
    } otpc_pins_t;

endpackage : otpc_pkg

// File: hw/otpc_timer.sv
// down-counter used for pulse width and settle waits
// assumes load and count in one clock domain
module otpc_timer #(
    parameter int W = 16
) (
    input  wire logic         i_clk_sys,   // clock
    input  wire logic         i_arst_n,    // async reset
    input  wire logic         i_load,      // start count
    input  wire logic [W-1:0] i_value,     // cycles to wait
    output logic              o_done       // level, count at zero
);
    logic [W-1:0] count;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
        end else if (i_load) begin
            count <= i_value;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign o_done = (count == '0) && !i_load;
endmodule : otpc_timer

// File: hw/otpc_host.sv
// host controller driving a one-time-programmable memory by its pins
// assumes device pins are sampled synchronously; supplies switched by external drivers
module otpc_host #(
    parameter int PULSE_CYCLES = otpc_pkg::PULSE_CYC,
    parameter int MAX_PULSE_CNT = otpc_pkg::MAX_PULSES
) (
    input  wire logic                       i_clk_sys,     // 200 MHz clock
    input  wire logic                       i_arst_n,      // async reset, low
    input  wire logic                       i_req_valid,   // request pulse
    input  wire otpc_pkg::otpc_req_t        i_req,         // request fields
    input  wire logic [15:0]                i_wdata,       // word to program
    input  wire logic [14:0]                i_data_lines,  // data pins in
    input  wire logic                       i_top_data,    // shared top pin in
    output logic                            o_busy,        // operation running
    output logic                            o_done,        // one-cycle done
    output logic                            o_error,       // verify failure
    output logic [15:0]                     o_rdata,       // read result
    output otpc_pkg::otpc_pins_t            o_pins,        // control pins
    output logic [14:0]                     o_data_lines,  // data pins out
    output logic                            o_data_oe,     // data pins driven
    output logic                            o_top_data,    // top pin out
    output logic                            o_top_oe       // top pin driven
);
    typedef enum logic [3:0] {
        S_IDLE, S_SUPPLY, S_SETUP, S_PULSE, S_VSETUP, S_VSAMPLE,
        S_READ, S_NEXT, S_FINISH
    } otpc_state_t;

    otpc_state_t          state;
    otpc_pkg::otpc_req_t  req;
    logic [4:0]           pulses;
    logic                 tmr_load;
    logic [15:0]          tmr_value;
    logic                 tmr_done;
    logic [18:0]          prev_addr;
    logic                 page_hit;
    logic [15:0]          sample;
    logic                 is_prog;
    logic                 match;
    logic                 page_end;

    // ****************************************
    // read-back and timing selection
    // ****************************************
    assign sample = req.byte_mode ? {8'h00, i_data_lines[7:0]}
                                  : {i_top_data, i_data_lines};
    assign page_hit = (prev_addr[18:3] == req.addr[18:3]) && !o_pins.ce_n;
    assign is_prog = (req.cmd == otpc_pkg::OTPC_CMD_PROG);
    assign match = (sample == i_wdata);
    assign page_end = (req.addr[2:0] == 3'h7);

    otpc_timer #(.W(16)) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_load    (tmr_load),
        .i_value   (tmr_value),
        .o_done    (tmr_done)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state        <= S_IDLE;
            req          <= '0;
            pulses       <= 5'h00;
            tmr_load     <= 1'b0;
            tmr_value    <= 16'h0000;
            prev_addr    <= 19'h00000;
            o_busy       <= 1'b0;
            o_done       <= 1'b0;
            o_error      <= 1'b0;
            o_rdata      <= 16'h0000;
            o_pins       <= '{ce_n: 1'b1, oe_n: 1'b1, prog_supply: 1'b0, core_high: 1'b0,
                              ident_hv: 1'b0, byte_sel_n: 1'b1, addr: 19'h00000};
            o_data_lines <= 15'h0000;
            o_data_oe    <= 1'b0;
            o_top_data   <= 1'b0;
            o_top_oe     <= 1'b0;
        end else begin
            tmr_load <= 1'b0;
            o_done   <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (i_req_valid) begin
                        req     <= i_req;
                        o_busy  <= 1'b1;
                        o_error <= 1'b0;
                        pulses  <= 5'h00;
                        o_pins.byte_sel_n <= !i_req.byte_mode;
                        if (i_req.cmd == otpc_pkg::OTPC_CMD_PROG) begin
                            o_pins.prog_supply <= 1'b1;
                            o_pins.core_high   <= 1'b1;
                            o_pins.oe_n        <= 1'b1;
                            o_pins.ce_n        <= 1'b1;
                            o_pins.byte_sel_n  <= 1'b1;
                            tmr_value <= 16'(otpc_pkg::SUPPLY_CYC);
                            tmr_load  <= 1'b1;
                            state     <= S_SUPPLY;
                        end else begin
                            o_pins.ident_hv <= (i_req.cmd == otpc_pkg::OTPC_CMD_IDENT);
                            if (i_req.cmd == otpc_pkg::OTPC_CMD_IDENT) begin
                                o_pins.addr <= {18'h00000, i_req.addr[0]};
                            end else begin
                                o_pins.addr <= i_req.addr;
                            end
                            o_top_oe   <= i_req.byte_mode;
                            o_top_data <= i_req.byte_hi;
                            o_pins.ce_n <= 1'b0;
                            o_pins.oe_n <= 1'b0;
                            tmr_value <= 16'((page_hit && i_req.addr[18:3] == prev_addr[18:3])
                                         ? otpc_pkg::PAGE_CYC : otpc_pkg::ACCESS_CYC);
                            tmr_load  <= 1'b1;
                            state     <= S_READ;
                        end
                    end else begin
                        o_pins.ce_n <= 1'b1;
                        o_pins.oe_n <= 1'b1;
                    end
                end
                S_SUPPLY, S_SETUP: begin
                    o_pins.addr  <= req.addr;
                    o_data_lines <= i_wdata[14:0];
                    o_top_data   <= i_wdata[15];
                    o_data_oe    <= 1'b1;
                    o_top_oe     <= 1'b1;
                    if (tmr_done && !tmr_load) begin
                        if (state == S_SUPPLY) begin
                            tmr_value <= 16'(otpc_pkg::SETTLE_CYC);
                            tmr_load  <= 1'b1;
                            state     <= S_SETUP;
                        end else begin
                            o_pins.ce_n <= 1'b0;
                            pulses      <= pulses + 5'h01;
                            // load and done each add a cycle of low time
                            tmr_value   <= 16'(PULSE_CYCLES - 2);
                            tmr_load    <= 1'b1;
                            state       <= S_PULSE;
                        end
                    end
                end
                S_PULSE: begin
                    if (tmr_done && !tmr_load) begin
                        // data held past the rising edge of the pulse
                        o_pins.ce_n <= 1'b1;
                        tmr_value   <= 16'(otpc_pkg::SETTLE_CYC);
                        tmr_load    <= 1'b1;
                        state       <= S_VSETUP;
                    end
                end
                S_VSETUP: begin
                    // data released a cycle before output enable drops
                    o_pins.oe_n <= o_data_oe;
                    o_data_oe   <= 1'b0;
                    o_top_oe    <= 1'b0;
                    if (tmr_done && !tmr_load) begin
                        tmr_value <= 16'(otpc_pkg::ACCESS_CYC);
                        tmr_load  <= 1'b1;
                        state     <= S_VSAMPLE;
                    end
                end
                S_VSAMPLE: begin
                    if (tmr_done && !tmr_load) begin
                        o_pins.oe_n <= 1'b1;
                        o_rdata     <= sample;
                        if (match) begin
                            state <= S_NEXT;
                        end else if (pulses >= 5'(MAX_PULSE_CNT)) begin
                            o_error <= 1'b1;
                            state   <= S_NEXT;
                        end else begin
                            tmr_value <= 16'(otpc_pkg::SETTLE_CYC);
                            tmr_load  <= 1'b1;
                            state     <= S_SETUP;
                        end
                    end
                end
                S_READ: begin
                    if (tmr_done && !tmr_load) begin
                        o_rdata   <= sample;
                        prev_addr <= req.addr;
                        if (req.cmd == otpc_pkg::OTPC_CMD_VERIFY_ALL && sample != i_wdata) begin
                            o_error <= 1'b1;
                        end
                        state <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    pulses <= 5'h00;
                    if ((is_prog || req.cmd == otpc_pkg::OTPC_CMD_VERIFY_ALL)
                        && req.addr != req.last) begin
                        req.addr <= req.addr + 19'h00001;
                        o_pins.addr <= req.addr + 19'h00001;
                        o_pins.oe_n <= is_prog;
                        tmr_value <= 16'(is_prog ? otpc_pkg::SETTLE_CYC
                                     : (page_end ? otpc_pkg::ACCESS_CYC
                                     : otpc_pkg::PAGE_CYC));
                        tmr_load  <= 1'b1;
                        state     <= is_prog ? S_SETUP : S_READ;
                    end else begin
                        state <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    o_pins.ce_n        <= 1'b1;
                    o_pins.oe_n        <= 1'b1;
                    o_pins.prog_supply <= 1'b0;
                    o_pins.core_high   <= 1'b0;
                    o_pins.ident_hv    <= 1'b0;
                    o_data_oe          <= 1'b0;
                    o_top_oe           <= 1'b0;
                    o_busy             <= 1'b0;
                    o_done             <= 1'b1;
                    state              <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule : otpc_host

// File: dv/otpc_host_checker.sv
// pin-level checks for the memory host controller
// assumes it is bound onto otpc_host
module otpc_host_checker #(
    parameter int PULSE_CYCLES  = 20,
    parameter int MAX_PULSE_CNT = 25
) (
    input wire logic                 i_clk_sys,    // clock
    input wire logic                 i_arst_n,     // reset
    input wire otpc_pkg::otpc_pins_t o_pins,       // control pins
    input wire logic [14:0]          o_data_lines, // data out
    input wire logic                 o_data_oe,    // data drive
    input wire logic                 o_top_oe      // top drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // pulse counters
    // ****************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    int          low_cnt;
    int          pulse_cnt;
    logic [18:0] last_addr;
    logic        ce_q;
    wire new_pulse = ce_q && !o_pins.ce_n;
    wire restart   = !o_pins.prog_supply || (o_pins.addr != last_addr);
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_cnt   <= 0;
            pulse_cnt <= 0;
            last_addr <= '0;
            ce_q      <= 1'b1;
        end else begin
            low_cnt   <= o_pins.ce_n ? 0 : low_cnt + 1;
            pulse_cnt <= restart ? 0 : pulse_cnt + int'(new_pulse);
            last_addr <= o_pins.addr;
            ce_q      <= o_pins.ce_n;
        end
    end
    a_pulse_width: assert property ($rose(o_pins.ce_n) && o_pins.prog_supply |->
        low_cnt == PULSE_CYCLES) else $error("program pulse width wrong");
    a_pulse_stable: assert property (!o_pins.ce_n && o_pins.prog_supply |->
        o_data_oe && o_top_oe && $stable(o_data_lines) && $stable(o_pins.addr))
        else $error("inputs moved during pulse");
    a_prog_entry: assert property (o_pins.prog_supply |-> o_pins.core_high)
        else $error("program supply without core raise");
    a_prog_oe_high: assert property (!o_pins.ce_n && o_pins.prog_supply |-> o_pins.oe_n)
        else $error("output enable low during pulse");
    a_verify_pins: assert property (o_pins.prog_supply && !o_pins.oe_n |->
        o_pins.ce_n && !o_data_oe && !o_top_oe) else $error("verify pins wrong");
    a_retry_limit: assert property (pulse_cnt <= MAX_PULSE_CNT)
        else $error("too many pulses on one address");
    a_ident_addr: assert property (o_pins.ident_hv |-> o_pins.addr[18:1] == '0)
        else $error("identify address not low");
    a_read_normal: assert property (!o_pins.ce_n && !o_pins.oe_n |->
        !o_pins.prog_supply && !o_pins.core_high && !o_data_oe)
        else $error("read with raised supply or driven data");
    a_byte_select: assert property (!o_pins.ce_n && !o_pins.oe_n |->
        o_top_oe == !o_pins.byte_sel_n) else $error("top pin drive wrong");
endmodule : otpc_host_checker

// File: dv/otpc_mem_model.sv
// behavioural model of the memory on the controller pins
// assumes the bench resolves the shared data wires
module otpc_mem_model #(
    parameter logic [15:0] MAKER_ID  = 16'h8003, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h0007  // arbitrary value
) (
    input wire otpc_pkg::otpc_pins_t i_pins, // control pins
    input wire logic [15:0]          i_bus,  // resolved data wires
    output logic [15:0]              o_q,    // data out
    output logic [15:0]              o_q_oe  // per-bit drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // array and pins
    // ****************
    logic [15:0] mem [0:15];
    int          pulses [0:15];
    wire       ce_n  = i_pins.ce_n;
    wire [3:0] a     = i_pins.addr[3:0];
    wire       bmode = !i_pins.byte_sel_n;
    wire [15:0] code = i_pins.addr[0] ? DEVICE_ID : MAKER_ID;
    wire [15:0] word = i_pins.ident_hv ? code : mem[a];
    wire rd = !i_pins.oe_n && (!ce_n || i_pins.prog_supply);
    assign o_q = bmode ? {8'h00, i_bus[15] ? word[15:8] : word[7:0]} : word;
    assign o_q_oe = !rd ? 16'h0000 : (bmode ? 16'h00ff : 16'hffff);
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'hffff;
            pulses[i] = 0;
        end
    end
    // cell 5 takes three pulses, cell 6 never takes
    always @(posedge ce_n) begin
        if (i_pins.prog_supply && i_pins.core_high && i_pins.oe_n) begin
            pulses[a] = pulses[a] + 1;
            if (a != 4'h6 && (a != 4'h5 || pulses[a] >= 3)) mem[a] = mem[a] & i_bus;
        end
    end
endmodule : otpc_mem_model

// File: dv/otpc_host_tb.sv
// self-checking bench for the memory host controller
// assumes the memory model and checker files are compiled first
module otpc_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // wiring
    // ****************
    localparam logic [15:0] MK = 16'h8003;
    localparam logic [15:0] DV = 16'h0007;
    logic                 i_clk_sys = 1'b0;
    logic                 i_arst_n  = 1'b0;
    logic                 i_req_valid = 1'b0;
    otpc_pkg::otpc_req_t  i_req = '0;
    logic [15:0]          i_wdata = 16'h0000;
    logic                 o_busy, o_done, o_error, o_data_oe, o_top_data, o_top_oe;
    logic [15:0]          o_rdata, q, q_oe, bus, flt = 16'h5555;
    logic [14:0]          o_data_lines;
    otpc_pkg::otpc_pins_t o_pins;
    int                   failures = 0, checks = 0, pulses = 0;
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) flt <= ~flt;
    always @(negedge o_pins.ce_n) if (o_pins.prog_supply) pulses++;
    for (genvar i = 0; i < 16; i++) begin : g_wire
        wire hd = (i == 15) ? o_top_oe : o_data_oe;
        wire hv = (i == 15) ? o_top_data : o_data_lines[i % 15];
        assign bus[i] = hd ? hv : (q_oe[i] ? q[i] : flt[i]);
    end
    otpc_host #(.PULSE_CYCLES(20), .MAX_PULSE_CNT(25)) dut (.i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req(i_req), .i_wdata(i_wdata),
        .i_data_lines(bus[14:0]), .i_top_data(bus[15]), .o_busy(o_busy), .o_done(o_done),
        .o_error(o_error), .o_rdata(o_rdata), .o_pins(o_pins), .o_data_lines(o_data_lines),
        .o_data_oe(o_data_oe), .o_top_data(o_top_data), .o_top_oe(o_top_oe));
    otpc_mem_model #(.MAKER_ID(MK), .DEVICE_ID(DV)) u_mem (.i_pins(o_pins), .i_bus(bus),
        .o_q(q), .o_q_oe(q_oe));
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp16
    task automatic run(input otpc_pkg::otpc_cmd_t c, input logic [18:0] a, input logic [18:0] l,
                       input logic bh, input logic [15:0] w);
        int n;
        pulses = 0;
        @(posedge i_clk_sys);
        i_req <= '{cmd: c, addr: a, last: l, byte_mode: bh !== 1'bz && c == otpc_pkg::OTPC_CMD_READ
                   && a[18], byte_hi: bh};
        i_wdata <= w;
        i_req_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (o_done !== 1'b1 && n < 5000);
        if (n >= 5000) cmp16(16'h0001, 16'h0000);
    endtask : run
    task automatic t_program;
        run(otpc_pkg::OTPC_CMD_READ, 19'h0, 19'h0, 1'b0, 16'h0);
        cmp16(o_rdata, 16'hffff);
        cmp16({14'h0, o_busy, o_pins.ce_n}, 16'h0001);
        run(otpc_pkg::OTPC_CMD_PROG, 19'h2, 19'h3, 1'b0, 16'ha5c3);
        cmp16(16'(pulses), 16'h0002);
        cmp16({15'h0, o_error}, 16'h0000);
        run(otpc_pkg::OTPC_CMD_READ, 19'h3, 19'h3, 1'b0, 16'h0);
        cmp16(o_rdata, 16'ha5c3);
    endtask : t_program
    task automatic t_retry;
        run(otpc_pkg::OTPC_CMD_PROG, 19'h5, 19'h5, 1'b0, 16'h0f0f);
        cmp16(16'(pulses), 16'h0003);
        cmp16({15'h0, o_error}, 16'h0000);
        run(otpc_pkg::OTPC_CMD_PROG, 19'h6, 19'h6, 1'b0, 16'h0f0f);
        cmp16(16'(pulses), 16'h0019);
        cmp16({15'h0, o_error}, 16'h0001);
    endtask : t_retry
    task automatic t_byte_ident;
        run(otpc_pkg::OTPC_CMD_READ, 19'h40002, 19'h0, 1'b1, 16'h0);
        cmp16({8'h00, o_rdata[7:0]}, 16'h00a5);
        run(otpc_pkg::OTPC_CMD_READ, 19'h40002, 19'h0, 1'b0, 16'h0);
        cmp16({8'h00, o_rdata[7:0]}, 16'h00c3);
        run(otpc_pkg::OTPC_CMD_IDENT, 19'h0, 19'h0, 1'b0, 16'h0);
        cmp16(o_rdata, MK);
        cmp16({15'h0, ^o_rdata}, 16'h0001);
        run(otpc_pkg::OTPC_CMD_IDENT, 19'h1, 19'h0, 1'b0, 16'h0);
        cmp16(o_rdata, DV);
    endtask : t_byte_ident
    task automatic t_verify;
        run(otpc_pkg::OTPC_CMD_VERIFY_ALL, 19'h2, 19'h3, 1'b0, 16'ha5c3);
        cmp16({15'h0, o_error}, 16'h0000);
        run(otpc_pkg::OTPC_CMD_VERIFY_ALL, 19'h2, 19'h3, 1'b0, 16'hffff);
        cmp16({15'h0, o_error}, 16'h0001);
    endtask : t_verify
    task automatic complete_run;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #200us;
        failures++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        t_program();
        t_retry();
        t_byte_ident();
        t_verify();
        complete_run();
    end
endmodule : otpc_host_tb
bind otpc_host otpc_host_checker #(.PULSE_CYCLES(PULSE_CYCLES), .MAX_PULSE_CNT(MAX_PULSE_CNT))
    u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .o_pins(o_pins),
           .o_data_lines(o_data_lines), .o_data_oe(o_data_oe), .o_top_oe(o_top_oe));
